//--- fieldbus_publisher_pkg.sv
package fieldbus_publisher_pkg;

  // ==========================================================================
  // Time base
  // ==========================================================================
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_PERIOD_NS = 1000;
  localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int DIV_W = 7;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_CYCLES - 1);

  // ==========================================================================
  // Latency figures, in milliseconds and in microsecond ticks
  // ==========================================================================
  localparam int LAT_W = 16;
  localparam int BASE_LATENCY_MS = 1;
  localparam int MAX_LATENCY_MS = 30;
  localparam int US_PER_MS = 1000;
  localparam logic [LAT_W-1:0] BASE_LATENCY_US = LAT_W'(BASE_LATENCY_MS * US_PER_MS);
  localparam logic [LAT_W-1:0] MAX_LATENCY_US = LAT_W'(MAX_LATENCY_MS * US_PER_MS);
  localparam logic [LAT_W-1:0] LATENCY_RESET = 16'h03E8;

  // ==========================================================================
  // Sizes
  // ==========================================================================
  localparam int NUM_CALCS = 8;
  localparam int CALC_LAT_W = 12;
  localparam int SUM_W = 18;
  localparam int TIME_W = 32;
  localparam int DEPTH = 16;
  localparam int PTR_W = 4;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] DEPTH_CNT = 5'h10;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [1:0] {
    SYNC_DC = 2'b01,
    SYNC_SM = 2'b10
  } sync_mode_type;

  typedef enum logic [1:0] {
    ST_WAIT_SYNC = 2'b01,
    ST_RUN = 2'b10
  } run_state_type;

  typedef struct packed {
    logic [TIME_W-1:0] stamp_us;
    logic [7:0] channel;
    logic [63:0] value;
  } result_type;

  typedef struct packed {
    logic [NUM_CALCS-1:0] active;
    logic [NUM_CALCS*CALC_LAT_W-1:0] increase_us;
  } calc_latency_type;

endpackage : fieldbus_publisher_pkg

//--- latency_summer.sv
`timescale 1ns/1ps
`default_nettype none
module latency_summer (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire fieldbus_publisher_pkg::calc_latency_type calc_i,
  output logic [fieldbus_publisher_pkg::SUM_W-1:0] sum_us_o,
  output logic [fieldbus_publisher_pkg::NUM_CALCS-1:0] increased_o
);
  import fieldbus_publisher_pkg::*;

  logic [SUM_W-1:0] part [NUM_CALCS+1];
  logic [NUM_CALCS-1:0] nonzero;
  logic [SUM_W-1:0] sum_d;
  logic [NUM_CALCS-1:0] flags_d;

  assign part[0] = '0;

  // ==========================================================================
  // Per-calculation contribution
  // ==========================================================================
  for (genvar g = 0; g < NUM_CALCS; g++) begin : g_calc
    logic [CALC_LAT_W-1:0] inc;
    assign inc = calc_i.increase_us[g*CALC_LAT_W +: CALC_LAT_W];
    assign nonzero[g] = calc_i.active[g] && (inc != '0); // R4
    assign part[g+1] = part[g] + (calc_i.active[g] ? SUM_W'(inc) : '0); // R5
  end

  always_comb begin
    sum_d = part[NUM_CALCS];
    flags_d = nonzero;
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      sum_us_o <= '0;
      increased_o <= '0;
    end else begin
      sum_us_o <= sum_d;
      increased_o <= flags_d;
    end
  end

  property p_flags;
    @(posedge clock_i) disable iff (!rst_n_i)
      1'b1 |=> increased_o == $past(nonzero);
  endproperty
  a_flags: assert property (p_flags) else $error("latency flags do not follow increases"); // R4

endmodule : latency_summer
`default_nettype wire

//--- fieldbus_publisher.sv
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// R1: With no extra latency every result is published exactly 1 ms after the instant it stands for.
// R2: Latency is referenced to the Sync0 pulse in distributed-clock mode, else to the sync-manager event.
// R3: The master must run the device synchronised; without a valid mode nothing is published; a result due in the first invalid-mode cycle is still published.
// R4: Each calculation that waits for a zero crossing adds latency and is flagged as doing so.
// R5: System latency is the sum of all per-calculation increases plus a 1 ms base.
// R6: The system latency is readable only; no input can overwrite it.
// R7: All channels are published with the same single system latency.
// R8: An extended latency is capped at 30 ms; a sum plus base above 30 ms is kept as it is, and flagged as capped only if an extension is asked.
// R9: The master polls process data no faster than once per millisecond.
// R10: Results wait in a delay buffer until reference time reaches stamp plus system latency.
module fieldbus_publisher (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire fieldbus_publisher_pkg::sync_mode_type sync_mode_i,
  input wire logic sync0_pulse_i,
  input wire logic sm_event_i,
  input wire fieldbus_publisher_pkg::calc_latency_type calc_i,
  input wire logic [fieldbus_publisher_pkg::LAT_W-1:0] extend_us_i,
  input wire logic result_valid_i,
  input wire fieldbus_publisher_pkg::result_type result_i,
  output logic result_ready_o,
  output logic publish_valid_o,
  output fieldbus_publisher_pkg::result_type publish_o,
  output logic [fieldbus_publisher_pkg::LAT_W-1:0] system_latency_o,
  output logic [fieldbus_publisher_pkg::NUM_CALCS-1:0] latency_increased_o,
  output logic latency_capped_o,
  output logic [fieldbus_publisher_pkg::TIME_W-1:0] ref_time_o,
  output logic sync_error_o
);
  import fieldbus_publisher_pkg::*;

  // ==========================================================================
  // Declarations
  // ==========================================================================
  run_state_type state_q, state_d;
  logic [DIV_W-1:0] div_q, div_d;
  logic tick_q, tick_d;
  logic [TIME_W-1:0] now_q, now_d;
  logic [LAT_W-1:0] latency_q, latency_d;
  logic capped_q, capped_d;
  logic sync_err_q, sync_err_d;
  logic [SUM_W-1:0] sum_us;
  logic [SUM_W-1:0] total_us;
  logic [SUM_W-1:0] extended_us;
  logic mode_ok;
  logic sync_evt;
  result_type mem [DEPTH];
  logic [PTR_W-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [CNT_W-1:0] count_q, count_d;
  logic ready_q, ready_d;
  logic pub_valid_q, pub_valid_d;
  result_type pub_q, pub_d;
  logic push, pop;
  logic [TIME_W-1:0] elapsed;

  latency_summer u_sum (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .calc_i(calc_i),
    .sum_us_o(sum_us),
    .increased_o(latency_increased_o)
  );

  // ==========================================================================
  // Sync reference and microsecond time base
  // ==========================================================================
  always_comb begin
    mode_ok = (sync_mode_i == SYNC_DC) || (sync_mode_i == SYNC_SM); // R3
    sync_evt = (sync_mode_i == SYNC_DC) ? sync0_pulse_i // R2
             : (sync_mode_i == SYNC_SM) ? sm_event_i : 1'b0;
    sync_err_d = !mode_ok;
    state_d = state_q;
    div_d = div_q;
    tick_d = 1'b0;
    now_d = now_q;
    case (state_q)
      ST_WAIT_SYNC: begin
        if (sync_evt) begin
          state_d = ST_RUN;
          div_d = '0;
        end
      end
      ST_RUN: begin
        if (!mode_ok) begin
          state_d = ST_WAIT_SYNC; // R3
        end else if (sync_evt) begin
          // Restarting the divider pins the microsecond grid to the master's event.
          div_d = '0; // R2
        end else if (div_q == DIV_LAST) begin
          div_d = '0;
          tick_d = 1'b1;
        end else begin
          div_d = div_q + 1'b1;
        end
      end
      default: state_d = ST_WAIT_SYNC;
    endcase
    if (tick_q) begin
      now_d = now_q + 1'b1;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      state_q <= ST_WAIT_SYNC;
      div_q <= '0;
      tick_q <= 1'b0;
      now_q <= '0;
      sync_err_q <= 1'b0;
    end else begin
      state_q <= state_d;
      div_q <= div_d;
      tick_q <= tick_d;
      now_q <= now_d;
      sync_err_q <= sync_err_d;
    end
  end

  // ==========================================================================
  // System latency
  // ==========================================================================
  always_comb begin
    total_us = sum_us + SUM_W'(BASE_LATENCY_US); // R1 R5
    extended_us = total_us + SUM_W'(extend_us_i);
    capped_d = 1'b0;
    if (extend_us_i == '0 || extended_us <= SUM_W'(MAX_LATENCY_US)) begin
      latency_d = LAT_W'(extended_us);
    end else if (total_us > SUM_W'(MAX_LATENCY_US)) begin
      // Extension never shortens the latency the calculations need.
      latency_d = LAT_W'(total_us);
      capped_d = 1'b1;
    end else begin
      latency_d = MAX_LATENCY_US; // R8
      capped_d = 1'b1;
    end
  end

  // The latency is only ever computed, never loaded from outside.
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      latency_q <= LATENCY_RESET;
      capped_q <= 1'b0;
    end else begin
      latency_q <= latency_d; // R6
      capped_q <= capped_d;
    end
  end

  // ==========================================================================
  // Delay buffer
  // ==========================================================================
  always_comb begin
    elapsed = now_q - mem[rd_q].stamp_us;
    push = result_valid_i && ready_q;
    // One latency for every channel keeps all published data on one clock instant.
    pop = (state_q == ST_RUN) && (count_q != '0) &&
          (elapsed >= TIME_W'(latency_q)); // R7 R10
    wr_d = push ? wr_q + 1'b1 : wr_q;
    rd_d = pop ? rd_q + 1'b1 : rd_q;
    count_d = count_q + CNT_W'(push) - CNT_W'(pop);
    ready_d = (count_d != DEPTH_CNT);
    pub_valid_d = pop;
    pub_d = pop ? mem[rd_q] : pub_q;
  end

  always_ff @(posedge clock_i) begin
    if (push) begin
      mem[wr_q] <= result_i;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      wr_q <= '0;
      rd_q <= '0;
      count_q <= '0;
      ready_q <= 1'b0;
      pub_valid_q <= 1'b0;
      pub_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      count_q <= count_d;
      ready_q <= ready_d;
      pub_valid_q <= pub_valid_d;
      pub_q <= pub_d;
    end
  end

  assign result_ready_o = ready_q;
  assign publish_valid_o = pub_valid_q;
  assign publish_o = pub_q;
  assign system_latency_o = latency_q;
  assign latency_capped_o = capped_q;
  assign ref_time_o = now_q;
  assign sync_error_o = sync_err_q;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  sequence s_no_extra;
    (calc_i.active == '0) && (extend_us_i == '0);
  endsequence

  property p_base_latency;
    @(posedge clock_i) disable iff (!rst_n_i)
      s_no_extra [*3] |-> latency_q == BASE_LATENCY_US;
  endproperty
  a_base_latency: assert property (p_base_latency) else $error("base latency not 1 ms"); // R1

  property p_sum_latency;
    @(posedge clock_i) disable iff (!rst_n_i)
      (extend_us_i == '0) |=> latency_q == LAT_W'($past(sum_us) + SUM_W'(BASE_LATENCY_US));
  endproperty
  a_sum_latency: assert property (p_sum_latency) else $error("latency not sum plus base"); // R5

  property p_cap;
    @(posedge clock_i) disable iff (!rst_n_i)
      capped_q |-> (latency_q == MAX_LATENCY_US) || (latency_q > MAX_LATENCY_US
        && $past(extend_us_i) != '0);
  endproperty
  a_cap: assert property (p_cap) else $error("extended latency above cap"); // R8

  property p_release_due;
    @(posedge clock_i) disable iff (!rst_n_i)
      pub_valid_q |-> $past(now_q) - pub_q.stamp_us >= TIME_W'($past(latency_q));
  endproperty
  a_release_due: assert property (p_release_due) else $error("result published early"); // R10

  property p_release_late;
    @(posedge clock_i) disable iff (!rst_n_i)
      (state_q == ST_RUN && count_q != '0 && elapsed >= TIME_W'(latency_q)) |=> pub_valid_q;
  endproperty
  a_release_late: assert property (p_release_late) else $error("due result held back"); // R10

  property p_sync_align;
    @(posedge clock_i) disable iff (!rst_n_i)
      (state_q == ST_RUN && mode_ok && sync_evt) |=> div_q == '0 ##1 !tick_q;
  endproperty
  a_sync_align: assert property (p_sync_align) else $error("grid not aligned to sync"); // R2

  property p_tick_spacing;
    @(posedge clock_i) disable iff (!rst_n_i)
      tick_q |=> !tick_q [*8];
  endproperty
  a_tick_spacing: assert property (p_tick_spacing) else $error("microsecond ticks too close"); // R2

  property p_unsynced_silent;
    @(posedge clock_i) disable iff (!rst_n_i)
      (state_q == ST_WAIT_SYNC) |=> !pub_valid_q;
  endproperty
  a_unsynced_silent: assert property (p_unsynced_silent) else $error("published without sync"); // R3

  property p_full_stall;
    @(posedge clock_i) disable iff (!rst_n_i)
      (count_q == DEPTH_CNT) |-> !ready_q;
  endproperty
  a_full_stall: assert property (p_full_stall) else $error("ready while buffer full"); // R10

endmodule : fieldbus_publisher
`default_nettype wire

//--- fieldbus_master_model.sv
`timescale 1ns/1ps
`default_nettype none
// ====================
// Master side of the process-data link
module fieldbus_master_model #(
  parameter int PERIOD = 100000
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire fieldbus_publisher_pkg::sync_mode_type mode_i,
  input wire logic go_i,
  input wire logic swap_i,
  output logic sync0_pulse_o,
  output logic sm_event_o
);
  import fieldbus_publisher_pkg::*;
  int count_q;
  logic fire;
  // The master never runs free: an event is issued only while go_i asks for one.
  assign fire = go_i && (count_q == 0);
  // One event per PERIOD cycles while go_i stays high; dropping and raising go_i again fires at once.
  always_ff @(posedge clock_i) begin
    if (!rst_n_i || !go_i) begin
      count_q <= 0;
    end else begin
      count_q <= (count_q == PERIOD - 1) ? 0 : count_q + 1;
    end
  end
  // Swapping sends the event on the line the device must ignore.
  assign sync0_pulse_o = fire && ((mode_i == SYNC_DC) != swap_i);
  assign sm_event_o = fire && ((mode_i == SYNC_SM) != swap_i);
endmodule : fieldbus_master_model
`default_nettype wire

//--- fieldbus_publisher_tb.sv
`timescale 1ns/1ps
`default_nettype none
module fieldbus_publisher_tb;
  import fieldbus_publisher_pkg::*;
  typedef struct {
    logic [7:0] act;
    logic [11:0] inc0;
    logic [11:0] inc1;
    logic [15:0] ext;
    logic [15:0] lat;
    logic [7:0] incd;
    logic cap;
  } row_type;
  row_type rows[5] = '{
    '{8'h00, 12'h000, 12'h000, 16'h0000, 16'h03E8, 8'h00, 1'b0},
    '{8'h03, 12'h03C, 12'h00C, 16'h0000, 16'h0430, 8'h03, 1'b0},
    '{8'h01, 12'h03C, 12'h00C, 16'h0000, 16'h0424, 8'h01, 1'b0},
    '{8'h03, 12'h03C, 12'h00C, 16'h0064, 16'h0494, 8'h03, 1'b0},
    '{8'h03, 12'h03C, 12'h00C, 16'h9C40, 16'h7530, 8'h03, 1'b1}};
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  sync_mode_type mode = SYNC_DC;
  logic go = 1'b0;
  logic swap = 1'b0;
  logic sync0, sm_ev;
  calc_latency_type calc = '0;
  logic [LAT_W-1:0] ext = '0;
  logic result_valid_i = 1'b0;
  result_type result_i = '0;
  logic result_ready_o, publish_valid_o, latency_capped_o, sync_error_o;
  result_type publish_o;
  logic [LAT_W-1:0] system_latency_o;
  logic [NUM_CALCS-1:0] latency_increased_o;
  logic [TIME_W-1:0] ref_time_o;
  int fail_count = 0;
  int num_checks = 0;
  logic [31:0] t;

  always #5 clock_i = ~clock_i;

  fieldbus_master_model fieldbus_master_model_i (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .mode_i(mode), .go_i(go), .swap_i(swap), .sync0_pulse_o(sync0), .sm_event_o(sm_ev));

  fieldbus_publisher fieldbus_publisher_i (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .sync_mode_i(mode), .sync0_pulse_i(sync0), .sm_event_i(sm_ev), .calc_i(calc),
    .extend_us_i(ext), .result_valid_i(result_valid_i), .result_i(result_i),
    .result_ready_o(result_ready_o), .publish_valid_o(publish_valid_o),
    .publish_o(publish_o), .system_latency_o(system_latency_o),
    .latency_increased_o(latency_increased_o), .latency_capped_o(latency_capped_o),
    .ref_time_o(ref_time_o), .sync_error_o(sync_error_o));

  // ====================
  // Shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic print_verdict;
    $display("checks %0d, mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : print_verdict

  // Request is held until an edge that samples ready high.
  task automatic push(input logic [7:0] ch, input logic [31:0] stamp);
    @(posedge clock_i);
    result_valid_i <= 1'b1;
    result_i <= {stamp, ch, 56'h0, ch};
    #1;
    for (int i = 0; i < 50; i++) begin
      if (result_ready_o === 1'b1) break;
      @(posedge clock_i);
      #1;
    end
    check(32'(result_ready_o), 32'h1);
    @(posedge clock_i);
    result_valid_i <= 1'b0;
  endtask : push

  // The publish must land exactly when reference time minus stamp equals the latency.
  task automatic expect_pub(input logic [7:0] ch, input logic [15:0] lat);
    for (int i = 0; i < 2000; i++) begin
      @(posedge clock_i);
      #1;
      if (publish_valid_o === 1'b1) break;
    end
    check(32'(publish_valid_o), 32'h1);
    check(ref_time_o - publish_o.stamp_us, 32'(lat));
    check(32'(publish_o.channel), 32'(ch));
    check(publish_o.value[31:0], 32'(ch));
  endtask : expect_pub

  initial begin
    repeat (20000) @(posedge clock_i);
    fail_count++;
    print_verdict();
  end

  // ====================
  // Test sequence
  initial begin
    repeat (16) @(posedge clock_i);
    rst_n_i <= 1'b1;
    @(posedge clock_i);
    #1;
    check(32'(system_latency_o), 32'h3E8);
    check(32'(publish_valid_o), 32'h0);
    $display("reset test done");
    foreach (rows[k]) begin
      @(posedge clock_i);
      calc <= {rows[k].act, 72'h0, rows[k].inc1, rows[k].inc0};
      ext <= rows[k].ext;
      repeat (3) @(posedge clock_i);
      #1;
      check(32'(system_latency_o), 32'(rows[k].lat));
      check(32'(latency_increased_o), 32'(rows[k].incd));
      check(32'(latency_capped_o), 32'(rows[k].cap));
      $display("latency row %0d done", k);
    end
    @(posedge clock_i);
    calc <= {8'hFF, {8{12'hFFF}}};
    ext <= 16'h0001;
    repeat (3) @(posedge clock_i);
    #1;
    check(32'(system_latency_o), 32'h83E0);
    check(32'(latency_capped_o), 32'h1);
    check(32'(latency_increased_o), 32'hFF);
    $display("long calculation test done");
    @(posedge clock_i);
    calc <= '0;
    ext <= '0;
    swap <= 1'b1;
    go <= 1'b1;
    repeat (300) @(posedge clock_i);
    #1;
    check(ref_time_o, 32'h0);
    @(posedge clock_i);
    go <= 1'b0;
    swap <= 1'b0;
    @(posedge clock_i);
    go <= 1'b1;
    repeat (350) @(posedge clock_i);
    #1;
    check(32'(ref_time_o >= 2 && ref_time_o <= 4), 32'h1);
    // A second Sync0 while running must restart the microsecond grid.
    @(posedge clock_i);
    go <= 1'b0;
    @(posedge clock_i);
    go <= 1'b1;
    repeat (150) @(posedge clock_i);
    #1;
    check(ref_time_o, 32'h4);
    $display("sync reference test done");
    t = ref_time_o;
    push(8'h01, t - 32'h3E8 + 32'h3);
    expect_pub(8'h01, 16'h03E8);
    t = ref_time_o;
    push(8'h02, t - 32'h3E8 + 32'h2);
    push(8'h03, t - 32'h3E8 + 32'h2);
    expect_pub(8'h02, 16'h03E8);
    expect_pub(8'h03, 16'h03E8);
    $display("publish timing test done");
    @(posedge clock_i);
    ext <= 16'h9C40;
    repeat (3) @(posedge clock_i);
    #1;
    t = ref_time_o;
    push(8'h04, t - 32'h7530 + 32'h2);
    expect_pub(8'h04, 16'h7530);
    $display("extended latency test done");
    @(posedge clock_i);
    mode <= sync_mode_type'(2'b11);
    repeat (3) @(posedge clock_i);
    #1;
    check(32'(sync_error_o), 32'h1);
    push(8'h05, ref_time_o - 32'h7530);
    repeat (300) begin
      @(posedge clock_i);
      #1;
      if (publish_valid_o !== 1'b0) check(32'(publish_valid_o), 32'h0);
    end
    check(32'(sync_error_o), 32'h1);
    $display("invalid mode test done");
    t = ref_time_o;
    @(posedge clock_i);
    mode <= SYNC_SM;
    swap <= 1'b1;
    go <= 1'b0;
    @(posedge clock_i);
    go <= 1'b1;
    repeat (200) @(posedge clock_i);
    #1;
    check(ref_time_o, t);
    check(32'(sync_error_o), 32'h0);
    @(posedge clock_i);
    go <= 1'b0;
    swap <= 1'b0;
    @(posedge clock_i);
    go <= 1'b1;
    expect_pub(8'h05, 16'h7530);
    $display("sync manager test done");
    print_verdict();
  end
endmodule : fieldbus_publisher_tb
`default_nettype wire
